// *** logic/bsc_top.sv ***
// Synchronism-check block: compares the bus voltage set with the line
// voltage and releases breaker close requests. Measurements come from a
// phasor front end with a one-cycle valid strobe; registers are reached over
// a plain address/strobe port with read data one cycle after the strobe.
// Assumes one clock, an asynchronous active-high reset, request levels that
// are already synchronous to the clock, and a front end that keeps its
// magnitudes, angles and frequencies in the scaling of the package.
`timescale 1ns/10ps
`include "bsc_cfg.svh"

// Operation
// - First three voltage channels are the bus voltages.
// - Fourth channel is line voltage, compared with configured bus phase.
// - Evaluate magnitude difference, angle difference and slip frequency.
// - Supervise manual, automatic or both close requests as configured.
// - Slip is absolute bus frequency minus line frequency.
// - Synchronous only while all three quantities are within limits.
// - Mode selects machine-to-grid or grid-to-grid behaviour.
// - Machine-to-grid close-angle check uses breaker closing time.
// - Advance release by slip times closing time to hit zero angle.
// - Grid-to-grid mode ignores closing time, no advance.
// - Enabled dead/live overrides permit closing without the check.
// - External bypass permits closing; its source must ensure synchronism.
module bsc_top (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic [7:0]          ADDR,
  input  wire logic [31:0]         WR_DATA,
  input  wire logic                WR_STB,
  input  wire logic                RD_STB,
  output logic [31:0]              RD_DATA,
  input  wire logic                MEAS_VALID,
  input  wire bsc_pkg::bsc_meas_type MEAS,
  input  wire bsc_pkg::bsc_req_type  REQ,
  output logic                     SYNC_OK,
  output logic                     CLOSE_RELEASE,
  output logic                     OVERRIDE_ACTIVE
);
  import bsc_pkg::*;

  bsc_ctrl_type ctrl_q;
  logic [15:0]  vdiff_lim_q;
  logic [15:0]  slip_lim_q;
  logic [15:0]  angle_lim_q;
  logic [15:0]  dead_thr_q;
  logic [15:0]  live_thr_q;
  logic [15:0]  close_time_q;

  // First stage: raw differences of one measurement set.
  logic [15:0]  vdiff_q;
  logic [23:0]  slip_q;
  logic         bus_fast_q;
  logic [15:0]  angle_q;
  logic         bus_live_q;
  logic         bus_dead_q;
  logic         line_live_q;
  logic         line_dead_q;
  logic         stage1_q;

  // Second stage: limit checks.
  logic         vdiff_ok_q;
  logic         slip_ok_q;
  logic         angle_ok_q;
  logic         override_q;
  logic [15:0]  pred_angle_q;

  logic [15:0]  bus_mag [3];
  logic [15:0]  bus_ang [3];
  logic [2:0]   ph_live;
  logic [2:0]   ph_dead;
  logic [15:0]  sel_mag;
  logic [15:0]  sel_ang;
  logic [15:0]  vdiff_d;
  logic [23:0]  slip_d;
  logic [15:0]  angle_d;
  logic [31:0]  adv_prod;
  logic [15:0]  adv;
  logic [15:0]  pred_angle_d;
  logic [15:0]  pred_abs;
  logic         permit;
  logic         supervised;
  logic         any_req;
  logic [31:0]  rd_data_d;
  logic [31:0]  adv_scaled;
  logic         adv_sat;
  bsc_ctrl_type ctrl_wr;

  // The control word keeps bit 7 unused while the register type packs its
  // fields without a gap, so the reset value and the write image both skip
  // that bit; casting the raw word would shift the phase select down by one.
  localparam logic [9:0]   ctrl_rst_word = `BSC_RST_CTRL;
  localparam bsc_ctrl_type ctrl_rst      =
    bsc_ctrl_type'({ctrl_rst_word[`BSC_CTRL_PHASE_HI:`BSC_CTRL_PHASE_LO],
                    ctrl_rst_word[`BSC_CTRL_EN_DEAD_BUS_DEAD_LINE_OVERRIDE:`BSC_CTRL_ENABLE]});

  // The three bus channels, phase-to-neutral or phase-to-phase alike.
  // The block never needs to know which, as long as both sides scale alike.
  assign bus_mag[0] = MEAS.bus_phase_a_voltage;
  assign bus_mag[1] = MEAS.bus_phase_b_voltage;
  assign bus_mag[2] = MEAS.bus_phase_c_voltage;
  assign bus_ang[0] = MEAS.bus_phase_a_angle;
  assign bus_ang[1] = MEAS.bus_phase_b_angle;
  assign bus_ang[2] = MEAS.bus_phase_c_angle;

  // Per-phase dead and live classification of the bus. A phase that sits
  // between the two thresholds is neither, so a sagging bus blocks the
  // overrides rather than being mistaken for a dead one.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
      assign ph_live[gi] = (bus_mag[gi] >= live_thr_q);
      assign ph_dead[gi] = (bus_mag[gi] <  dead_thr_q);
    end
  endgenerate

  // Bus phase that the line channel is compared with; the spare code
  // falls back to phase A so a bad setting never blocks the check.
  // Angles travel with the magnitudes so that both come from one phase.
  always_comb begin
    case (ctrl_q.phase_select)
      BSC_PHASE_B: begin
        sel_mag = bus_mag[1];
        sel_ang = bus_ang[1];
      end
      BSC_PHASE_C: begin
        sel_mag = bus_mag[2];
        sel_ang = bus_ang[2];
      end
      default: begin
        sel_mag = bus_mag[0];
        sel_ang = bus_ang[0];
      end
    endcase
  end

  // Raw differences; the angle subtraction wraps, which is what we want,
  // since a half turn either way is the largest error that can exist.
  // Magnitude and slip use an ordered subtraction so neither can wrap.
  always_comb begin
    if (sel_mag >= MEAS.line_side_voltage) begin
      vdiff_d = sel_mag - MEAS.line_side_voltage;
    end else begin
      vdiff_d = MEAS.line_side_voltage - sel_mag;
    end
    if (MEAS.bus_frequency >= MEAS.line_frequency) begin
      slip_d = MEAS.bus_frequency - MEAS.line_frequency;
    end else begin
      slip_d = MEAS.line_frequency - MEAS.bus_frequency;
    end
    angle_d = sel_ang - MEAS.line_side_angle;
  end

  // Stage one captures a new set on each measurement strobe.
  // Between strobes the inputs are ignored, so the front end may let them
  // wander; the results of the last set stand until the next one.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      vdiff_q     <= 16'h0000;
      slip_q      <= 24'h000000;
      bus_fast_q  <= 1'b0;
      angle_q     <= 16'h0000;
      bus_live_q  <= 1'b0;
      bus_dead_q  <= 1'b0;
      line_live_q <= 1'b0;
      line_dead_q <= 1'b0;
    end else if (MEAS_VALID) begin
      vdiff_q     <= vdiff_d;
      slip_q      <= slip_d;
      bus_fast_q  <= (MEAS.bus_frequency > MEAS.line_frequency);
      angle_q     <= angle_d;
      bus_live_q  <= &ph_live;
      bus_dead_q  <= &ph_dead;
      line_live_q <= (MEAS.line_side_voltage >= live_thr_q);
      line_dead_q <= (MEAS.line_side_voltage <  dead_thr_q);
    end
  end

  // Stage-one valid marker, one cycle behind the strobe.
  // It gates stage two, so each set is judged exactly once.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stage1_q <= 1'b0;
    end else begin
      stage1_q <= MEAS_VALID;
    end
  end

  // Close-angle advance: the angle moves by slip times closing time while
  // the breaker travels. Saturating keeps a wild slip from wrapping the
  // prediction back into the window.
  assign adv_prod   = slip_q[15:0] * close_time_q;
  assign adv_scaled = adv_prod >> `BSC_ADV_SHIFT;

  // Only the low 16 bits of the slip enter the product, so a slip of 2^16
  // units or more saturates as well; the check window is far smaller anyway.
  assign adv_sat    = (adv_scaled > 32'h0000_7FFF) ||
                      (slip_q[23:16] != 8'h00);

  // Grid-to-grid closing takes no advance: the closing time plays no part
  // there, so the raw angle is what is judged.
  always_comb begin
    if (ctrl_q.synchronization_mode_select == BSC_GRID_TO_GRID_MODE) begin
      adv = 16'h0000;
    end else if (adv_sat) begin
      adv = 16'h7FFF;
    end else begin
      adv = adv_scaled[15:0];
    end
    // A faster bus drives the angle upward, so look ahead in that sense.
    if (bus_fast_q) begin
      pred_angle_d = angle_q + adv;
    end else begin
      pred_angle_d = angle_q - adv;
    end
    if (pred_angle_d[15]) begin
      pred_abs = 16'h0000 - pred_angle_d;
    end else begin
      pred_abs = pred_angle_d;
    end
  end

  // Stage two: limit checks and override states, refreshed per set.
  // The predicted angle is kept for readback so software can see how far
  // the advance moved the window.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      vdiff_ok_q   <= 1'b0;
      slip_ok_q    <= 1'b0;
      angle_ok_q   <= 1'b0;
      override_q   <= 1'b0;
      pred_angle_q <= 16'h0000;
    end else if (stage1_q) begin
      vdiff_ok_q   <= (vdiff_q <= vdiff_lim_q);
      slip_ok_q    <= (slip_q <= {8'h00, slip_lim_q});
      angle_ok_q   <= (pred_abs <= angle_lim_q);
      pred_angle_q <= pred_angle_d;
      override_q   <=
        (ctrl_q.live_bus_dead_line_override && bus_live_q && line_dead_q) ||
        (ctrl_q.dead_bus_live_line_override && bus_dead_q && line_live_q) ||
        (ctrl_q.dead_bus_dead_line_override && bus_dead_q && line_dead_q);
    end
  end

  // A request from a supervised source needs a permit; an unsupervised
  // source passes straight through while the block is enabled and no supervised request is present.
  assign any_req    = REQ.manual_close || REQ.auto_close;
  assign supervised = (REQ.manual_close && ctrl_q.supervise_manual) ||
                      (REQ.auto_close && ctrl_q.supervise_auto);
  // The permit uses the reported levels, not the stage-two flags, so a
  // release never leads the SYNC_OK or OVERRIDE_ACTIVE that justify it.
  assign permit     = SYNC_OK || OVERRIDE_ACTIVE ||
                      REQ.external_bypass;

  // Outputs come from flip-flops; all drop while the block is disabled.
  // Disabling also stops unsupervised requests: a switched-off check
  // releases nothing at all.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SYNC_OK         <= 1'b0;
      CLOSE_RELEASE   <= 1'b0;
      OVERRIDE_ACTIVE <= 1'b0;
    end else if (!ctrl_q.enable) begin
      SYNC_OK         <= 1'b0;
      CLOSE_RELEASE   <= 1'b0;
      OVERRIDE_ACTIVE <= 1'b0;
    end else begin
      SYNC_OK         <= vdiff_ok_q && slip_ok_q && angle_ok_q;
      OVERRIDE_ACTIVE <= override_q || REQ.external_bypass;
      CLOSE_RELEASE   <= any_req && (!supervised || permit);
    end
  end

  // Write image of the control word with the unused bit 7 squeezed out.
  assign ctrl_wr = bsc_ctrl_type'(
    {WR_DATA[`BSC_CTRL_PHASE_HI:`BSC_CTRL_PHASE_LO],
     WR_DATA[`BSC_CTRL_EN_DEAD_BUS_DEAD_LINE_OVERRIDE:`BSC_CTRL_ENABLE]});

  // Register writes; unmapped or read-only addresses are ignored.
  // New limits and thresholds take effect with the next measurement set.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q       <= ctrl_rst;
      vdiff_lim_q  <= `BSC_RST_VDIFF_LIM;
      slip_lim_q   <= `BSC_RST_SLIP_LIM;
      angle_lim_q  <= `BSC_RST_ANGLE_LIM;
      dead_thr_q   <= `BSC_RST_DEAD_THR;
      live_thr_q   <= `BSC_RST_LIVE_THR;
      close_time_q <= `BSC_RST_CLOSE_TIME;
    end else if (WR_STB) begin
      case (ADDR)
        `BSC_ADDR_CTRL: begin
          ctrl_q <= ctrl_wr;
        end
        `BSC_ADDR_VDIFF_LIM:  vdiff_lim_q  <= WR_DATA[15:0];
        `BSC_ADDR_SLIP_LIM:   slip_lim_q   <= WR_DATA[15:0];
        `BSC_ADDR_ANGLE_LIM:  angle_lim_q  <= WR_DATA[15:0];
        `BSC_ADDR_DEAD_THR:   dead_thr_q   <= WR_DATA[15:0];
        `BSC_ADDR_LIVE_THR:   live_thr_q   <= WR_DATA[15:0];
        `BSC_ADDR_CLOSE_TIME: close_time_q <= WR_DATA[15:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; bit 7 of the control word reads as zero. Status and measured
  // values are live views, so a read shows the state of its own cycle.
  always_comb begin
    case (ADDR)
      `BSC_ADDR_CTRL: begin
        rd_data_d = {22'h000000, ctrl_q.phase_select, 1'b0,
                     ctrl_q[`BSC_CTRL_EN_DEAD_BUS_DEAD_LINE_OVERRIDE:`BSC_CTRL_ENABLE]};
      end
      `BSC_ADDR_VDIFF_LIM:  rd_data_d = {16'h0000, vdiff_lim_q};
      `BSC_ADDR_SLIP_LIM:   rd_data_d = {16'h0000, slip_lim_q};
      `BSC_ADDR_ANGLE_LIM:  rd_data_d = {16'h0000, angle_lim_q};
      `BSC_ADDR_DEAD_THR:   rd_data_d = {16'h0000, dead_thr_q};
      `BSC_ADDR_LIVE_THR:   rd_data_d = {16'h0000, live_thr_q};
      `BSC_ADDR_CLOSE_TIME: rd_data_d = {16'h0000, close_time_q};
      `BSC_ADDR_STATUS: begin
        rd_data_d = {20'h00000, line_dead_q, line_live_q, bus_dead_q,
                     bus_live_q, 1'b0, OVERRIDE_ACTIVE, CLOSE_RELEASE,
                     SYNC_OK, angle_ok_q, slip_ok_q, vdiff_ok_q,
                     override_q};
      end
      `BSC_ADDR_MEAS_VDIFF: rd_data_d = {16'h0000, vdiff_q};
      `BSC_ADDR_MEAS_SLIP:  rd_data_d = {8'h00, slip_q};
      `BSC_ADDR_MEAS_ANGLE: rd_data_d = {angle_q, pred_angle_q};
      default:              rd_data_d = `BSC_ZERO32;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  // Zero between reads keeps a stale word from looking like a fresh one.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RD_DATA <= `BSC_ZERO32;
    end else if (RD_STB) begin
      RD_DATA <= rd_data_d;
    end else begin
      RD_DATA <= `BSC_ZERO32;
    end
  end

endmodule

// *** logic/bsc_cfg.svh ***
// Address map, field positions, reset values and scaling for the
// synchronism-check block. Included by the block's top module, its checker and its bench.
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// Register byte addresses, one 32-bit word each.
`define BSC_ADDR_CTRL       8'h00
`define BSC_ADDR_VDIFF_LIM  8'h04
`define BSC_ADDR_SLIP_LIM   8'h08
`define BSC_ADDR_ANGLE_LIM  8'h0C
`define BSC_ADDR_DEAD_THR   8'h10
`define BSC_ADDR_LIVE_THR   8'h14
`define BSC_ADDR_CLOSE_TIME 8'h18
`define BSC_ADDR_STATUS     8'h1C
`define BSC_ADDR_MEAS_VDIFF 8'h20
`define BSC_ADDR_MEAS_SLIP  8'h24
`define BSC_ADDR_MEAS_ANGLE 8'h28

// Control register field positions.
`define BSC_CTRL_ENABLE     0
`define BSC_CTRL_MODE       1
`define BSC_CTRL_SUP_MAN    2
`define BSC_CTRL_SUP_AUTO   3
`define BSC_CTRL_EN_LIVE_BUS_DEAD_LINE_OVERRIDE    4
`define BSC_CTRL_EN_DEAD_BUS_LIVE_LINE_OVERRIDE    5
`define BSC_CTRL_EN_DEAD_BUS_DEAD_LINE_OVERRIDE    6
`define BSC_CTRL_PHASE_LO   8
`define BSC_CTRL_PHASE_HI   9

// Reset values.
`define BSC_RST_CTRL        10'h00C
`define BSC_RST_VDIFF_LIM   16'h0400
`define BSC_RST_SLIP_LIM    16'h0100
`define BSC_RST_ANGLE_LIM   16'h0380
`define BSC_RST_DEAD_THR    16'h0800
`define BSC_RST_LIVE_THR    16'h3000
`define BSC_RST_CLOSE_TIME  16'h0050

// Slip (2^-12 Hz) times close time (2^-10 s) gives 2^-22 turn; the
// angle scale is 2^-16 turn, so the product is shifted right by six.
`define BSC_ADV_SHIFT       6
`define BSC_ZERO32          32'h0000_0000

`endif

// *** logic/bsc_pkg.sv ***
// Types shared by the synchronism-check block and its surroundings.
// Assumes the constants header is on the include path.
package bsc_pkg;

  // Magnitudes in raw units, angles as 2^-16 of a turn, two's complement.
  typedef struct packed {
    logic [15:0] bus_phase_a_voltage;
    logic [15:0] bus_phase_b_voltage;
    logic [15:0] bus_phase_c_voltage;
    logic [15:0] line_side_voltage;
    logic [15:0] bus_phase_a_angle;
    logic [15:0] bus_phase_b_angle;
    logic [15:0] bus_phase_c_angle;
    logic [15:0] line_side_angle;
    logic [23:0] bus_frequency;
    logic [23:0] line_frequency;
  } bsc_meas_type;

  typedef enum logic {
    BSC_GRID_TO_GRID_MODE,
    BSC_MACHINE_TO_GRID_MODE
  } bsc_mode_type;

  typedef enum logic [1:0] {
    BSC_PHASE_A,
    BSC_PHASE_B,
    BSC_PHASE_C,
    BSC_PHASE_SPARE
  } bsc_phase_type;

  typedef struct packed {
    bsc_phase_type phase_select;
    logic          dead_bus_dead_line_override;
    logic          dead_bus_live_line_override;
    logic          live_bus_dead_line_override;
    logic          supervise_auto;
    logic          supervise_manual;
    bsc_mode_type  synchronization_mode_select;
    logic          enable;
  } bsc_ctrl_type;

  typedef struct packed {
    logic manual_close;
    logic auto_close;
    logic external_bypass;
  } bsc_req_type;

endpackage

// *** verif/bsc_checker.sv ***
// Concurrent checks on the ports of the synchronism-check block.
// Assumes the constants header on the include path and one clock domain.
`timescale 1ns/10ps
`include "bsc_cfg.svh"
module bsc_checker (
  input wire logic                CLK,
  input wire logic                RST,
  input wire logic [7:0]          ADDR,
  input wire logic [31:0]         WR_DATA,
  input wire logic                WR_STB,
  input wire logic                RD_STB,
  input wire logic [31:0]         RD_DATA,
  input wire bsc_pkg::bsc_req_type REQ,
  input wire logic                SYNC_OK,
  input wire logic                CLOSE_RELEASE,
  input wire logic                OVERRIDE_ACTIVE
);
  import bsc_pkg::*;
  logic [9:0] ctrl_q;
  logic       en;
  logic       man_sup;
  logic       man_only;

  // Shadow of the control word; bit 7 is reserved and always reads zero.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= `BSC_RST_CTRL;
    end else if (WR_STB && ADDR == `BSC_ADDR_CTRL) begin
      ctrl_q <= WR_DATA[9:0] & 10'h37F;
    end
  end

  // Request qualifiers derived from the shadow and the request levels.
  assign en       = ctrl_q[`BSC_CTRL_ENABLE];
  assign man_sup  = en && ctrl_q[`BSC_CTRL_SUP_MAN];
  assign man_only = REQ.manual_close && !REQ.auto_close &&
                    !REQ.external_bypass;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence rd_status;
    RD_STB && ADDR == `BSC_ADDR_STATUS;
  endsequence
  sequence rd_ctrl;
    RD_STB && ADDR == `BSC_ADDR_CTRL;
  endsequence
  sequence quiet_bus;
    !RD_STB ##1 1'b1;
  endsequence

  read_gap_zero_a: assert property (quiet_bus |-> RD_DATA == `BSC_ZERO32)
    else $error("read data seen without a read strobe");
  ctrl_readback_a: assert property (rd_ctrl |=>
    RD_DATA == {22'h0, $past(ctrl_q)})
    else $error("control readback differs from last write");
  status_bits_a: assert property (rd_status |=>
    RD_DATA[6:4] == $past({OVERRIDE_ACTIVE, CLOSE_RELEASE, SYNC_OK}))
    else $error("status does not mirror output levels");
  off_no_sync_a: assert property (!en [*2] |-> !SYNC_OK)
    else $error("sync reported while disabled");
  off_no_release_a: assert property (!en [*2] |->
    !CLOSE_RELEASE && !OVERRIDE_ACTIVE)
    else $error("release or override while disabled");
  sup_needs_permit_a: assert property ($past(man_sup && man_only) &&
    CLOSE_RELEASE |-> $past(SYNC_OK || OVERRIDE_ACTIVE))
    else $error("supervised close released without permit");
  unsup_passes_a: assert property ($past(en && REQ.manual_close &&
    !ctrl_q[`BSC_CTRL_SUP_MAN]) |-> CLOSE_RELEASE)
    else $error("unsupervised close request not passed");
  bypass_shows_a: assert property ($past(en &&
    REQ.external_bypass) |-> OVERRIDE_ACTIVE)
    else $error("bypass not shown one cycle later");
  release_needs_req_a: assert property (CLOSE_RELEASE |->
    $past(REQ.manual_close || REQ.auto_close))
    else $error("release without a close request");
endmodule

bind bsc_top bsc_checker chk (.CLK(CLK), .RST(RST), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
  .REQ(REQ), .SYNC_OK(SYNC_OK), .CLOSE_RELEASE(CLOSE_RELEASE),
  .OVERRIDE_ACTIVE(OVERRIDE_ACTIVE));

// *** verif/bsc_front_end.sv ***
// Model of the measurement front end: one set per one-cycle send pulse.
// Assumes send is raised just after a rising edge for one cycle.
`timescale 1ns/10ps
module bsc_front_end (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  send,
  input  wire bsc_pkg::bsc_meas_type meas_in,
  output logic                       meas_valid,
  output bsc_pkg::bsc_meas_type      meas
);
  import bsc_pkg::*;
  bsc_meas_type held_q;

  // Launch the strobe one edge after the request, with the set beside it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meas_valid <= 1'b0;
      held_q     <= '0;
    end else begin
      meas_valid <= send;
      if (send) begin
        held_q <= meas_in;
      end
    end
  end

  // Between strobes the bus shows the inverse, so a stray sample is caught.
  assign meas = meas_valid ? held_q : ~held_q;
endmodule

// *** verif/bsc_top_bench.sv ***
// Self-checking bench for the synchronism-check block.
// Assumes the design, its package, the checker and the front end model.
`timescale 1ns/10ps
`include "bsc_cfg.svh"
module bsc_top_bench;
  import bsc_pkg::*;
  logic         clk, rst, wr_stb, rd_stb, send, meas_valid, rd_seen;
  logic [7:0]   addr;
  logic [31:0]  wr_data, rd_data;
  bsc_meas_type meas, meas_in, m;
  bsc_req_type  req;
  logic [15:0]  v;
  int           bad_count, samples_checked;
  logic [31:0]  exp_q[$];
  logic [31:0]  rv[7] = '{32'h00C, 32'h400, 32'h100, 32'h380, 32'h800,
                        32'h3000, 32'h50};
  logic [23:0]  fb[2] = '{24'h032101, 24'h031EFF};
  logic [31:0]  s_on[3] = '{32'h94D, 32'h64D, 32'hA5F};
  logic [31:0]  s_off[3] = '{32'h90C, 32'h60C, 32'hA1E};

  bsc_top uut (.CLK(clk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .MEAS_VALID(meas_valid), .MEAS(meas), .REQ(req), .SYNC_OK(),
    .CLOSE_RELEASE(), .OVERRIDE_ACTIVE());
  bsc_front_end fe (.clk(clk), .rst(rst), .send(send), .meas_in(meas_in),
    .meas_valid(meas_valid), .meas(meas));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch rd_data expected %h seen %h", e, s);
    end
  endtask

  // One bus cycle; on a read, d is the expected word and is queued.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    wr_stb  <= w;
    rd_stb  <= !w;
    addr    <= a;
    wr_data <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // Send a set and wait out the front end and the three-stage pipeline.
  task automatic put(input bsc_meas_type x);
    meas_in <= x;
    send    <= 1'b1;
    idle(1);
    send <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  function automatic bsc_meas_type mk(input logic [15:0] b, l, ang,
                                      input logic [23:0] f);
    mk = '0;
    mk.bus_phase_a_voltage = b;
    mk.bus_phase_b_voltage = b;
    mk.bus_phase_c_voltage = b;
    mk.line_side_voltage   = l;
    mk.line_side_angle     = ang;
    mk.bus_frequency       = f;
    mk.line_frequency      = 24'h032000;
  endfunction

  // Read data stand only in the cycle after the strobe; compare them there.
  always @(posedge clk) begin
    rd_seen <= rd_stb;
    if (rd_seen) chk32(exp_q.pop_front(), rd_data);
  end

  // A hang is cut short here and counted.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  // Main sequence: reset, register defaults, then the checking scenarios.
  initial begin
    rst = 1'b1;
    {wr_stb, rd_stb, send} = 3'h0;
    addr = 8'h00;
    wr_data = 32'h0;
    meas_in = '0;
    req = '0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'h2628a401));
    v = 16'h3000 + 16'($urandom & 32'hFFF);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rv[i]) bus(1'b0, 8'(4 * i), rv[i]);
    bus(1'b0, 8'h30, 32'h0);
    bus(1'b1, `BSC_ADDR_CTRL, 32'h5);
    put(mk(v, v, 16'h0380, 24'h032000));
    bus(1'b0, `BSC_ADDR_STATUS, 32'h51E);
    put(mk(v, v, 16'h0381, 24'h032000));
    bus(1'b0, `BSC_ADDR_STATUS, 32'h506);
    m = mk(v, v, 16'h0, 24'h032000);
    m.bus_phase_b_voltage = v + 16'h0401;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `BSC_ADDR_CTRL, 32'h5 | (s << 8));
      put(m);
      bus(1'b0, `BSC_ADDR_STATUS, (s == 1) ? 32'h50C : 32'h51E);
    end
    bus(1'b1, `BSC_ADDR_CTRL, 32'h5);
    foreach (fb[i]) begin
      put(mk(v, v, 16'h0, fb[i]));
      bus(1'b0, `BSC_ADDR_MEAS_SLIP, 32'h101);
      bus(1'b0, `BSC_ADDR_STATUS, 32'h50A);
    end
    bus(1'b1, `BSC_ADDR_CLOSE_TIME, 32'h200);
    for (int md = 0; md < 2; md++) begin
      bus(1'b1, `BSC_ADDR_CTRL, 32'h5 | (md << 1));
      put(mk(v, v, 16'h0, 24'h032080));
      bus(1'b0, `BSC_ADDR_MEAS_ANGLE, md ? 32'h400 : 32'h0);
      bus(1'b0, `BSC_ADDR_STATUS, md ? 32'h506 : 32'h51E);
    end
    bus(1'b1, `BSC_ADDR_CTRL, 32'h5);
    put(mk(v, v, 16'h0, 24'h032000));
    req.manual_close <= 1'b1;
    idle(2);
    bus(1'b0, `BSC_ADDR_STATUS, 32'h53E);
    put(mk(v, v, 16'h0381, 24'h032000));
    bus(1'b0, `BSC_ADDR_STATUS, 32'h506);
    req.external_bypass <= 1'b1;
    idle(2);
    bus(1'b0, `BSC_ADDR_STATUS, 32'h566);
    req.external_bypass <= 1'b0;
    bus(1'b1, `BSC_ADDR_CTRL, 32'h9);
    idle(2);
    bus(1'b0, `BSC_ADDR_STATUS, 32'h526);
    req.manual_close <= 1'b0;
    req.auto_close   <= 1'b1;
    idle(2);
    bus(1'b0, `BSC_ADDR_STATUS, 32'h506);
    req.auto_close   <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      m = mk((k == 0) ? v : 16'h0, (k == 1) ? v : 16'h0, 16'h0, 24'h032000);
      bus(1'b1, `BSC_ADDR_CTRL, 32'h5 | (32'h70 & ~(32'h10 << k)));
      put(m);
      bus(1'b0, `BSC_ADDR_STATUS, s_off[k]);
      bus(1'b1, `BSC_ADDR_CTRL, 32'h5 | (32'h10 << k));
      put(m);
      bus(1'b0, `BSC_ADDR_STATUS, s_on[k]);
    end
    idle(3);
    give_verdict();
  end
endmodule
